//--- inc/amd_params.svh
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH

// Operand byte counts that follow the opcode
`define AMD_LEN_0 2'd0
`define AMD_LEN_1 2'd1
`define AMD_LEN_2 2'd2
// Byte slots inside the two-byte operand and pointer buffers
`define AMD_SLOT_0 1'b0
`define AMD_SLOT_1 1'b1
// Page-zero high byte and the pointer step between word halves
`define AMD_PAGE0_HI 8'h00
`define AMD_PTR_STEP 16'h0001
`define AMD_OPC_BYTES 16'h0001
`define AMD_ZERO16 16'h0000
`define AMD_ZERO8 8'h00

`endif

//--- inc/amd_pkg.sv
`default_nettype none
package amd_pkg;

  typedef enum logic [4:0] {
    AMD_INHERENT,
    AMD_IMMEDIATE,
    AMD_DIR_SHORT,
    AMD_DIR_LONG,
    AMD_IDX_NONE,
    AMD_IDX_SHORT,
    AMD_IDX_LONG,
    AMD_IND_SHORT,
    AMD_IND_LONG,
    AMD_INDX_SHORT,
    AMD_INDX_LONG,
    AMD_REL_DIR,
    AMD_REL_IND,
    AMD_BIT_DIR,
    AMD_BIT_IND,
    AMD_BIT_REL_DIR,
    AMD_BIT_REL_IND
  } amd_mode_t;

  // General ops exist in every form; short_only ops are the memory-to-memory,
  // bit, shift, swap, call and jump group
  typedef enum logic [1:0] {
    AMD_OP_GENERAL,
    AMD_OP_SHORT_ONLY,
    AMD_OP_FLOW
  } amd_opclass_t;

  typedef struct packed {
    amd_mode_t mode;
    amd_opclass_t opclass;
    logic idx_y;
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] y;
  } amd_req_t;

  typedef struct packed {
    amd_mode_t mode;
    logic [15:0] ea;
    logic [7:0] operand;
    logic is_value;
    logic is_branch;
    logic [15:0] target;
    logic [1:0] nbytes;
    logic illegal;
  } amd_res_t;

endpackage
`default_nettype wire

//--- rtl/amd_byte_slot.sv
`timescale 1ns/1ps
`default_nettype none
module amd_byte_slot #(
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  output logic [DEPTH-1:0][7:0] bytes
);
  logic [DEPTH-1:0][7:0] bytes_q;
  logic [DEPTH-1:0][7:0] bytes_d;

  always_comb begin
    bytes_d = bytes_q;
    if (clr) begin
      bytes_d = '0;
    end else if (wr_en) begin
      bytes_d[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bytes_q <= '0;
    end else begin
      bytes_q <= bytes_d;
    end
  end

  assign bytes = bytes_q;
endmodule
`default_nettype wire

//--- rtl/amd_addr_add.sv
`timescale 1ns/1ps
`default_nettype none
`include "amd_params.svh"
module amd_addr_add (
  input wire logic [15:0] base,
  input wire logic [7:0] off,
  input wire logic off_signed,
  output logic [15:0] sum
);
  logic [15:0] off_ext;

  // Unsigned offsets keep the carry into bit 8; signed ones wrap modulo 64K
  always_comb begin
    off_ext = off_signed ? {{8{off[7]}}, off} : {`AMD_ZERO8, off};
    sum = base + off_ext;
  end
endmodule
`default_nettype wire

//--- rtl/amd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "amd_params.svh"
// Overview of operation
// RULE1: Inherent instructions fetch no operand bytes
// RULE2: Immediate byte is the operand value itself
// RULE3: Direct address comes from bytes after opcode
// RULE4: Short direct address stays within 00-FF
// RULE5: Long direct fetches two-byte address word
// RULE6: Long forms reach full 64K, more bytes; long indirect here takes one operand byte, like short indirect
// RULE7: Short forms reach page zero only; the short indexed forms here reach up to 1FE
// RULE8: Indexed address is index plus offset, unsigned
// RULE9: No-offset indexed uses index alone, no byte
// RULE10: Short indexed keeps carry, reaching 1FE
// RULE11: Memory-to-memory ops exist only in short forms
// RULE12: Direct read-modify-write ops need short address
// RULE13: Indexed read-modify-write ops never use long offset
// RULE14: Relative adds signed 8-bit offset to PC
// RULE15: Long indirect pointer holds a full word
// RULE16: Report operand byte count to fetch unit
module amd_decoder
  import amd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire amd_req_t req,
  output logic req_ready,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  output logic fetch_ready,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic res_valid,
  output amd_res_t res
);

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_PTR, S_CALC} amd_state_t;

  amd_state_t state_q, state_d;
  amd_req_t req_q, req_d;
  logic [1:0] n_q, n_d;
  logic [1:0] cnt_q, cnt_d;
  logic illegal_q, illegal_d;
  logic [15:0] pc_end_q, pc_end_d;
  logic req_ready_q, req_ready_d;
  logic fetch_ready_q, fetch_ready_d;
  logic mem_rd_q, mem_rd_d;
  logic [15:0] mem_addr_q, mem_addr_d;
  logic res_valid_q, res_valid_d;
  amd_res_t res_q, res_d;

  logic req_fire, fetch_fire, mem_fire, slot_clr;
  logic [1:0][7:0] ob, pb;
  logic [7:0] idx;
  logic [15:0] idx_base, idx_sum, rel_base, rel_sum;
  logic [7:0] rel_off;
  logic long_form, ind_mode, ptr_word;

  assign req_fire = req_valid && req_ready_q;
  assign fetch_fire = fetch_valid && fetch_ready_q;
  assign mem_fire = mem_ack && mem_rd_q;
  assign slot_clr = req_fire;

  function automatic logic [1:0] op_len(input amd_mode_t m);
    unique case (m)
      AMD_INHERENT, AMD_IDX_NONE: op_len = `AMD_LEN_0; // RULE1 RULE9
      AMD_DIR_LONG, AMD_IDX_LONG, AMD_BIT_REL_DIR, AMD_BIT_REL_IND: op_len = `AMD_LEN_2; // RULE5
      default: op_len = `AMD_LEN_1;
    endcase
  endfunction

  function automatic logic is_long(input amd_mode_t m);
    is_long = (m == AMD_DIR_LONG) || (m == AMD_IDX_LONG) ||
              (m == AMD_IND_LONG) || (m == AMD_INDX_LONG);
  endfunction

  function automatic logic is_ind(input amd_mode_t m);
    is_ind = (m == AMD_IND_SHORT) || (m == AMD_IND_LONG) || (m == AMD_INDX_SHORT) ||
             (m == AMD_INDX_LONG) || (m == AMD_REL_IND) || (m == AMD_BIT_IND) ||
             (m == AMD_BIT_REL_IND);
  endfunction

  assign long_form = is_long(req.mode);
  assign ind_mode = is_ind(req_q.mode);
  assign ptr_word = (req_q.mode == AMD_IND_LONG) || (req_q.mode == AMD_INDX_LONG); // RULE15
  assign idx = req_q.idx_y ? req_q.y : req_q.x;

  amd_byte_slot #(.DEPTH(2)) u_operand (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clr(slot_clr),
    .wr_en(fetch_fire),
    .wr_idx(cnt_q[0]),
    .wr_data(fetch_byte),
    .bytes(ob)
  );

  amd_byte_slot #(.DEPTH(2)) u_pointer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clr(slot_clr),
    .wr_en(mem_fire),
    .wr_idx(cnt_q[0]),
    .wr_data(mem_rdata),
    .bytes(pb)
  );

  // Base for the indexed sum: offset bytes or fetched pointer
  always_comb begin
    unique case (req_q.mode)
      AMD_IDX_SHORT: idx_base = {`AMD_PAGE0_HI, ob[`AMD_SLOT_0]}; // RULE10
      AMD_IDX_LONG: idx_base = {ob[`AMD_SLOT_0], ob[`AMD_SLOT_1]}; // RULE8
      AMD_INDX_SHORT: idx_base = {`AMD_PAGE0_HI, pb[`AMD_SLOT_0]};
      AMD_INDX_LONG: idx_base = {pb[`AMD_SLOT_0], pb[`AMD_SLOT_1]};
      default: idx_base = `AMD_ZERO16; // RULE9
    endcase
  end

  always_comb begin
    unique case (req_q.mode)
      AMD_REL_IND: rel_off = pb[`AMD_SLOT_0];
      AMD_BIT_REL_DIR, AMD_BIT_REL_IND: rel_off = ob[`AMD_SLOT_1];
      default: rel_off = ob[`AMD_SLOT_0];
    endcase
  end
  assign rel_base = pc_end_q;

  amd_addr_add u_idx_add (
    .base(idx_base),
    .off(idx),
    .off_signed(1'b0),
    .sum(idx_sum)
  );

  amd_addr_add u_rel_add (
    .base(rel_base),
    .off(rel_off),
    .off_signed(1'b1),
    .sum(rel_sum)
  );

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    n_d = n_q;
    cnt_d = cnt_q;
    illegal_d = illegal_q;
    pc_end_d = pc_end_q;
    mem_addr_d = mem_addr_q;
    res_d = res_q;
    res_valid_d = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (req_fire) begin
          req_d = req;
          n_d = op_len(req.mode); // RULE16
          cnt_d = `AMD_LEN_0;
          // Short-only operations have no long form
          illegal_d = (req.opclass == AMD_OP_SHORT_ONLY) && long_form; // RULE11 RULE12 RULE13
          pc_end_d = req.pc + `AMD_OPC_BYTES + {14'h0000, op_len(req.mode)}; // RULE16
          state_d = (op_len(req.mode) == `AMD_LEN_0) ? S_CALC : S_FETCH; // RULE1
        end
      end
      S_FETCH: begin
        if (fetch_fire) begin
          cnt_d = cnt_q + 2'd1;
          if (cnt_q + 2'd1 == n_q) begin
            cnt_d = `AMD_LEN_0;
            if (ind_mode) begin
              // Pointer starts in page zero at the first operand byte; a word pointer at FF reads its second byte from 0100
              mem_addr_d = {`AMD_PAGE0_HI, ob[`AMD_SLOT_0]};
              if (n_q == `AMD_LEN_1) begin
                mem_addr_d = {`AMD_PAGE0_HI, fetch_byte};
              end
              state_d = S_PTR;
            end else begin
              state_d = S_CALC;
            end
          end
        end
      end
      S_PTR: begin
        if (mem_fire) begin
          if (ptr_word && cnt_q == `AMD_LEN_0) begin
            cnt_d = `AMD_LEN_1;
            mem_addr_d = mem_addr_q + `AMD_PTR_STEP; // RULE15
          end else begin
            cnt_d = `AMD_LEN_0;
            state_d = S_CALC;
          end
        end
      end
      S_CALC: begin
        res_d = '0;
        res_d.mode = req_q.mode;
        res_d.nbytes = n_q; // RULE16
        res_d.illegal = illegal_q;
        res_d.target = rel_sum;
        unique case (req_q.mode)
          AMD_INHERENT: res_d.ea = `AMD_ZERO16; // RULE1
          AMD_IMMEDIATE: begin
            res_d.operand = ob[`AMD_SLOT_0]; // RULE2
            res_d.is_value = 1'b1;
          end
          AMD_DIR_SHORT, AMD_BIT_DIR, AMD_BIT_REL_DIR:
            res_d.ea = {`AMD_PAGE0_HI, ob[`AMD_SLOT_0]}; // RULE3 RULE4 RULE7
          AMD_DIR_LONG: res_d.ea = {ob[`AMD_SLOT_0], ob[`AMD_SLOT_1]}; // RULE3 RULE5 RULE6
          AMD_IDX_NONE: res_d.ea = {`AMD_PAGE0_HI, idx}; // RULE9
          AMD_IDX_SHORT, AMD_IDX_LONG, AMD_INDX_SHORT, AMD_INDX_LONG:
            res_d.ea = idx_sum; // RULE8 RULE10
          AMD_IND_SHORT, AMD_BIT_IND, AMD_BIT_REL_IND:
            res_d.ea = {`AMD_PAGE0_HI, pb[`AMD_SLOT_0]}; // RULE7
          AMD_IND_LONG: res_d.ea = {pb[`AMD_SLOT_0], pb[`AMD_SLOT_1]}; // RULE15
          AMD_REL_DIR, AMD_REL_IND: res_d.ea = `AMD_ZERO16;
        endcase
        res_d.is_branch = (req_q.mode == AMD_REL_DIR) || (req_q.mode == AMD_REL_IND) ||
                          (req_q.mode == AMD_BIT_REL_DIR) ||
                          (req_q.mode == AMD_BIT_REL_IND); // RULE14
        res_valid_d = 1'b1;
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
    req_ready_d = (state_d == S_IDLE);
    fetch_ready_d = (state_d == S_FETCH);
    mem_rd_d = (state_d == S_PTR);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      req_q <= '0;
      n_q <= `AMD_LEN_0;
      cnt_q <= `AMD_LEN_0;
      illegal_q <= 1'b0;
      pc_end_q <= `AMD_ZERO16;
      req_ready_q <= 1'b0;
      fetch_ready_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_addr_q <= `AMD_ZERO16;
      res_valid_q <= 1'b0;
      res_q <= '0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      n_q <= n_d;
      cnt_q <= cnt_d;
      illegal_q <= illegal_d;
      pc_end_q <= pc_end_d;
      req_ready_q <= req_ready_d;
      fetch_ready_q <= fetch_ready_d;
      mem_rd_q <= mem_rd_d;
      mem_addr_q <= mem_addr_d;
      res_valid_q <= res_valid_d;
      res_q <= res_d;
    end
  end

  assign req_ready = req_ready_q;
  assign fetch_ready = fetch_ready_q;
  assign mem_rd = mem_rd_q;
  assign mem_addr = mem_addr_q;
  assign res_valid = res_valid_q;
  assign res = res_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_INH_NO_FETCH: assert property ( // RULE1
    req_fire && req.mode == AMD_INHERENT |=> !fetch_ready_q ##1 res_valid_q && res_q.nbytes == 2'd0)
    else $error("inherent instruction fetched operand bytes");
  AST_IMM_VALUE: assert property ( // RULE2
    res_valid_q && res_q.mode == AMD_IMMEDIATE |-> res_q.is_value && res_q.nbytes == 2'd1 &&
      res_q.operand == ob[0])
    else $error("immediate operand not taken as value");
  AST_DIR_SHORT_PAGE0: assert property ( // RULE4
    res_valid_q && res_q.mode == AMD_DIR_SHORT |-> res_q.ea == {8'h00, ob[0]} &&
      res_q.nbytes == 2'd1)
    else $error("short direct address outside page zero");
  AST_DIR_LONG_WORD: assert property ( // RULE5
    res_valid_q && res_q.mode == AMD_DIR_LONG |-> res_q.ea == {ob[0], ob[1]} &&
      res_q.nbytes == 2'd2)
    else $error("long direct address not formed from two bytes");
  AST_IDX_NONE: assert property ( // RULE9
    res_valid_q && res_q.mode == AMD_IDX_NONE |-> res_q.ea == {8'h00, idx} && res_q.nbytes == 2'd0)
    else $error("no-offset indexed address wrong");
  AST_IDX_SHORT_CARRY: assert property ( // RULE10
    res_valid_q && res_q.mode == AMD_IDX_SHORT |-> res_q.ea == 16'(ob[0]) + 16'(idx) &&
      res_q.ea[15:9] == 7'h00)
    else $error("short indexed sum wrong or carry lost");
  AST_SHORT_ONLY: assert property ( // RULE11
    req_fire && req.opclass == AMD_OP_SHORT_ONLY && is_long(req.mode) |->
      ##[1:8] res_valid_q && res_q.illegal)
    else $error("long form of short-only operation not flagged");
  AST_REL_TARGET: assert property ( // RULE14
    res_valid_q && res_q.mode == AMD_REL_DIR |-> res_q.is_branch &&
      res_q.target == pc_end_q + {{8{ob[0][7]}}, ob[0]})
    else $error("relative target wrong");
  AST_PTR_WORD: assert property ( // RULE15
    res_valid_q && res_q.mode == AMD_IND_LONG |-> res_q.ea == {pb[0], pb[1]})
    else $error("long indirect pointer not a word");
  AST_FETCH_COUNT: assert property ( // RULE16
    fetch_fire |-> cnt_q < n_q)
    else $error("fetched more operand bytes than reported");

  COV_IDX_CARRY: cover property (res_valid_q && res_q.mode == AMD_IDX_SHORT && res_q.ea[8]);
  COV_IND_LONG: cover property (res_valid_q && res_q.mode == AMD_IND_LONG);
  COV_ILLEGAL: cover property (res_valid_q && res_q.illegal);
  COV_BIT_REL_IND: cover property (res_valid_q && res_q.mode == AMD_BIT_REL_IND);
endmodule
`default_nettype wire

//--- bench/amd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module amd_decoder_tb
  import amd_pkg::*;
;
  logic core_clk, rst_n, req_valid, req_ready, fetch_valid, fetch_ready;
  logic mem_rd, mem_ack, res_valid;
  logic [7:0] fetch_byte, mem_rdata;
  logic [15:0] mem_addr;
  amd_req_t req;
  amd_res_t res;
  int n_fail, total_checks, nrd;
  logic [15:0] rd_addr [0:3];

  amd_decoder dut (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
    .fetch_ready(fetch_ready), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .res_valid(res_valid), .res(res)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Memory content derived from the address so every byte within one page is distinct
  function automatic logic [7:0] mv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  // One-cycle ack; data bus toggles when idle so stale bytes never match
  always @(posedge core_clk) begin
    if (mem_rd && !mem_ack) begin
      mem_ack <= 1'b1;
      mem_rdata <= mv(mem_addr);
      if (nrd < 4) rd_addr[nrd] <= mem_addr;
      nrd <= nrd + 1;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end

  task automatic tally_and_finish;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic hang(input string what);
    n_fail++;
    $display("CHECK FAILED t=%0t %s", $time, what);
    tally_and_finish();
  endtask

  task automatic decode(input amd_mode_t m, input amd_opclass_t oc, input logic iy,
      input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y, input int nb,
      input logic [15:0] ob);
    int n;
    nrd = 0;
    req_valid <= 1'b1;
    req <= '{mode: m, opclass: oc, idx_y: iy, pc: pc, x: x, y: y};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    if (req_ready !== 1'b1) hang("request not taken");
    req_valid <= 1'b0;
    req <= ~req;
    for (int i = 0; i < nb; i++) begin
      fetch_valid <= 1'b1;
      fetch_byte <= (i == 0) ? ob[15:8] : ob[7:0];
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (fetch_ready !== 1'b1 && n < 40);
      if (fetch_ready !== 1'b1) hang("operand byte not taken");
    end
    // Stream keeps offering bytes, so any extra fetch is caught
    fetch_valid <= 1'b1;
    fetch_byte <= ~fetch_byte;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (fetch_ready === 1'b1) chk(16'h0001, 16'h0000, "extra byte taken");
    end while (res_valid !== 1'b1 && n < 40);
    if (res_valid !== 1'b1) hang("no result");
    // Two cycles after the last byte, plus two per pointer read with this responder
    chk(16'(n), 16'(2 + 2 * nrd), "result latency");
    fetch_valid <= 1'b0;
    @(posedge core_clk);
    chk(16'(res_valid), 16'h0000, "result pulse too long");
  endtask

  task automatic t_counts;
    logic [1:0] nb [0:16] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h1, 2'h1,
                              2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
    for (int i = 0; i < 17; i++) begin
      decode(amd_mode_t'(i), AMD_OP_GENERAL, 1'b0, 16'h0400, 8'h03, 8'h04, nb[i], 16'h2102);
      chk(res.nbytes, nb[i], "byte count");
      chk(res.mode, 16'(i), "mode");
      chk(res.illegal, 16'h0000, "general flagged");
    end
  endtask

  task automatic t_imm;
    decode(AMD_IMMEDIATE, AMD_OP_GENERAL, 1'b0, 16'h2000, 8'h00, 8'h00, 1, 16'h5500);
    chk(res.operand, 16'h0055, "immediate value");
    chk(res.is_value, 16'h0001, "immediate kind");
  endtask

  task automatic t_direct;
    decode(AMD_DIR_SHORT, AMD_OP_GENERAL, 1'b0, 16'h2000, 8'h40, 8'h41, 1, 16'hff00);
    chk(res.ea, 16'h00ff, "short direct");
    chk(res.is_value, 16'h0000, "direct kind");
    decode(AMD_DIR_LONG, AMD_OP_GENERAL, 1'b0, 16'h2000, 8'h40, 8'h41, 2, 16'hbe5f);
    chk(res.ea, 16'hbe5f, "long direct");
  endtask

  task automatic t_indexed;
    decode(AMD_IDX_NONE, AMD_OP_GENERAL, 1'b0, 16'h3000, 8'hff, 8'h11, 0, 16'h0000);
    chk(res.ea, 16'h00ff, "no offset x");
    decode(AMD_IDX_NONE, AMD_OP_GENERAL, 1'b1, 16'h3000, 8'hff, 8'h7e, 0, 16'h0000);
    chk(res.ea, 16'h007e, "no offset y");
    decode(AMD_IDX_SHORT, AMD_OP_GENERAL, 1'b1, 16'h3000, 8'h00, 8'hff, 1, 16'hff00);
    chk(res.ea, 16'h01fe, "short offset carry");
    decode(AMD_IDX_LONG, AMD_OP_GENERAL, 1'b0, 16'h3000, 8'h80, 8'h01, 2, 16'h1280);
    chk(res.ea, 16'h1300, "long offset");
  endtask

  task automatic t_short_only;
    amd_mode_t ms [0:8] = '{AMD_DIR_LONG, AMD_IDX_LONG, AMD_IND_LONG, AMD_INDX_LONG,
                            AMD_DIR_SHORT, AMD_IDX_SHORT, AMD_IDX_NONE, AMD_IND_SHORT,
                            AMD_INDX_SHORT};
    logic [1:0] nb [0:8] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1};
    for (int i = 0; i < 9; i++) begin
      decode(ms[i], AMD_OP_SHORT_ONLY, 1'b0, 16'h0800, 8'h05, 8'h06, nb[i], 16'h3344);
      chk(res.illegal, 16'(i < 4), "short only op");
      chk(res.nbytes, nb[i], "refused op length");
    end
  endtask

  task automatic t_indirect;
    decode(AMD_IND_LONG, AMD_OP_GENERAL, 1'b0, 16'h5000, 8'h00, 8'h00, 1, 16'hff00);
    chk(16'(nrd), 16'h0002, "word pointer reads");
    chk(rd_addr[0], 16'h00ff, "pointer high addr");
    chk(rd_addr[1], 16'h0100, "pointer low addr");
    chk(res.ea, {mv(16'h00ff), mv(16'h0100)}, "long indirect");
    decode(AMD_IND_SHORT, AMD_OP_GENERAL, 1'b0, 16'h5000, 8'h00, 8'h00, 1, 16'h1000);
    chk(16'(nrd), 16'h0001, "byte pointer reads");
    chk(rd_addr[0], 16'h0010, "byte pointer addr");
    chk(res.ea, {8'h00, mv(16'h0010)}, "short indirect");
    decode(AMD_INDX_LONG, AMD_OP_GENERAL, 1'b1, 16'h5000, 8'h00, 8'hf0, 1, 16'h4000);
    chk(res.ea, {mv(16'h0040), mv(16'h0041)} + 16'h00f0, "indirect indexed");
  endtask

  task automatic t_relative;
    logic [7:0] d;
    d = mv(16'h0085);
    decode(AMD_REL_DIR, AMD_OP_FLOW, 1'b0, 16'h1000, 8'h00, 8'h00, 1, 16'h8000);
    chk(res.target, 16'h0f82, "backward branch");
    chk(res.is_branch, 16'h0001, "branch kind");
    decode(AMD_REL_DIR, AMD_OP_FLOW, 1'b0, 16'h1000, 8'h00, 8'h00, 1, 16'h7f00);
    chk(res.target, 16'h1081, "forward branch");
    decode(AMD_REL_IND, AMD_OP_FLOW, 1'b0, 16'h1000, 8'h00, 8'h00, 1, 16'h8500);
    chk(res.target, 16'h1002 + {{8{d[7]}}, d}, "offset from memory");
    decode(AMD_BIT_REL_DIR, AMD_OP_FLOW, 1'b0, 16'h1000, 8'h00, 8'h00, 2, 16'h10fe);
    chk(res.target, 16'h1001, "bit branch");
    chk(res.ea, 16'h0010, "bit address");
  endtask

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    fetch_valid = 1'b0;
    fetch_byte = 8'h00;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    n_fail = 0;
    total_checks = 0;
    nrd = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_counts();
    t_imm();
    t_direct();
    t_indexed();
    t_short_only();
    t_indirect();
    t_relative();
    tally_and_finish();
  end
endmodule
`default_nettype wire
